//--- design/css_pkg.sv
package css_pkg;
   // serial register map
   localparam logic [7:0] CSS_SYNC_CTRL_OFFSET     = 8'h0e;
   localparam int         CSS_SEP_SELECT_BIT       = 0;
   localparam logic [7:0] CSS_THRESHOLD_OFFSET     = 8'h11;
   localparam logic [7:0] CSS_THRESHOLD_RESET      = 8'h20;
   localparam logic       CSS_SEP_SELECT_RESET     = 1'b1;
   // timing: system clock and counting step
   localparam int         CSS_MCLK_HZ              = 100_000_000;
   localparam int         CSS_TICK_HZ              = 5_000_000;
   localparam int         CSS_TICK_CYCLES          = CSS_MCLK_HZ / CSS_TICK_HZ;
   localparam int         CSS_COUNT_WIDTH          = 8;

   // serial register write port
   typedef struct packed {
      logic       wr;
      logic [7:0] addr;
      logic [7:0] data;
   } css_reg_wr_s;

   // separator result
   typedef struct packed {
      logic       frame_sync;
      logic       searching;
      logic [7:0] count;
   } css_status_s;
endpackage

//--- design/css_tick_gen.sv
`timescale 1ns/10ps
// divides mclk down to a one-cycle count tick
module css_tick_gen
   import css_pkg::*;
#(
   parameter int DIV = CSS_TICK_CYCLES
) (
   // clock, reset and enable
   input  wire logic mclk,
   input  wire logic rstn,
   input  wire logic ce,
   // tick out
   output logic      tick
);
   localparam int CW = $clog2(DIV);
   logic [CW-1:0] cnt_reg;
   logic [CW-1:0] cnt_next;

   // next divider value
   always_comb begin
      if (cnt_reg == CW'(DIV - 1)) begin
         cnt_next = '0;
      end else begin
         cnt_next = cnt_reg + CW'(1);
      end
   end

   // divider register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cnt_reg <= '0;
      end else if (ce) begin
         cnt_reg <= cnt_next;
      end
   end

   assign tick = ce && (cnt_reg == CW'(DIV - 1));
endmodule

//--- design/css_sync_separator.sv
`timescale 1ns/10ps
module css_sync_separator
   import css_pkg::*;
#(
   parameter int TICK_DIV = CSS_TICK_CYCLES
) (
   // clock, reset, enable
   input  wire logic        mclk,
   input  wire logic        rstn,
   input  wire logic        ce,
   // sync inputs from pins
   input  wire logic        csync_in,
   input  wire logic        ext_frame_sync_in,
   // serial register port
   input  wire css_reg_wr_s reg_wr,
   input  wire logic [7:0]  reg_rd_addr,
   output logic [7:0]       reg_rd_data,
   // outputs
   output logic             frame_sync_out,
   output css_status_s      status
);
   typedef enum logic {CSS_SEARCH, CSS_ACTIVE} css_state_e;

   logic [1:0] csync_sync_reg;
   logic [1:0] ext_sync_reg;
   logic       tick;
   css_state_e state_reg;
   css_state_e state_next;
   logic [7:0] count_reg;
   logic [7:0] count_next;
   logic [7:0] threshold_reg;
   logic [7:0] threshold_next;
   logic       select_reg;
   logic       select_next;
   logic       out_reg;
   logic       out_next;
   logic       sync_act;
   logic       ext_act;

   // two-stage synchronisers for pin inputs
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         csync_sync_reg <= 2'h0;
         ext_sync_reg   <= 2'h0;
      end else if (ce) begin
         csync_sync_reg <= {csync_sync_reg[0], csync_in};
         ext_sync_reg   <= {ext_sync_reg[0], ext_frame_sync_in};
      end
   end
   assign sync_act = csync_sync_reg[1];
   assign ext_act  = ext_sync_reg[1];

   css_tick_gen #(
      .DIV (TICK_DIV)
   ) css_tick_gen_inst (
      .mclk (mclk),
      .rstn (rstn),
      .ce   (ce),
      .tick (tick)
   );

   // register writes
   always_comb begin
      threshold_next = threshold_reg;
      select_next    = select_reg;
      if (reg_wr.wr && reg_wr.addr == CSS_THRESHOLD_OFFSET) begin
         threshold_next = reg_wr.data;
      end
      if (reg_wr.wr && reg_wr.addr == CSS_SYNC_CTRL_OFFSET) begin
         select_next = reg_wr.data[CSS_SEP_SELECT_BIT];
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         threshold_reg <= CSS_THRESHOLD_RESET;
         select_reg    <= CSS_SEP_SELECT_RESET;
      end else if (ce) begin
         threshold_reg <= threshold_next;
         select_reg    <= select_next;
      end
   end

   // register readback
   always_comb begin
      reg_rd_data = 8'h00;
      if (reg_rd_addr == CSS_THRESHOLD_OFFSET) begin
         reg_rd_data = threshold_reg;
      end else if (reg_rd_addr == CSS_SYNC_CTRL_OFFSET) begin
         reg_rd_data[CSS_SEP_SELECT_BIT] = select_reg;
      end
   end

   // separator state machine and counter
   always_comb begin
      state_next = state_reg;
      count_next = count_reg;
      if (tick) begin
         case (state_reg)
            CSS_SEARCH: begin
               if (count_reg > threshold_reg) begin
                  state_next = CSS_ACTIVE;
                  count_next = 8'h00;
               end else if (sync_act) begin
                  if (count_reg != 8'hff) begin
                     count_next = count_reg + 8'h01;
                  end
               end else if (count_reg != 8'h00) begin
                  count_next = count_reg - 8'h01;
               end
            end
            CSS_ACTIVE: begin
               if (count_reg >= threshold_reg) begin
                  state_next = CSS_SEARCH;
                  count_next = 8'h00;
               end else if (!sync_act) begin
                  count_next = count_reg + 8'h01;
               end
            end
            default: begin
               state_next = CSS_SEARCH;
               count_next = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= CSS_SEARCH;
         count_reg <= 8'h00;
      end else if (ce) begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   always_comb begin
      out_next = select_reg ? (state_reg == CSS_ACTIVE) : ext_act;
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_reg <= 1'b0;
      end else if (ce) begin
         out_reg <= out_next;
      end
   end

   assign frame_sync_out    = out_reg;
   assign status.frame_sync = (state_reg == CSS_ACTIVE);
   assign status.searching  = (state_reg == CSS_SEARCH);
   assign status.count      = count_reg;

   // assertions
   // never wraps
   a_count_no_wrap: assert property (@(posedge mclk) disable iff (!rstn)
      ce && tick && state_reg == CSS_SEARCH && sync_act && count_reg == 8'hff && count_reg <= threshold_reg
      |=> count_reg == 8'hff) else $error("counter wrapped at top");
   a_ce_freeze: assert property (@(posedge mclk) disable iff (!rstn)
      !ce |=> $stable(count_reg) && $stable(state_reg) && $stable(threshold_reg))
      else $error("state moved while enable low");
   a_search_up: assert property (@(posedge mclk) disable iff (!rstn)
      ce && tick && state_reg == CSS_SEARCH && sync_act && count_reg <= threshold_reg && count_reg != 8'hff
      |=> count_reg == $past(count_reg) + 8'h01) else $error("search did not count up");
   a_search_down: assert property (@(posedge mclk) disable iff (!rstn)
      ce && tick && state_reg == CSS_SEARCH && !sync_act && count_reg <= threshold_reg
      |=> count_reg == ((($past(count_reg)) == 8'h00) ? 8'h00 : $past(count_reg) - 8'h01))
      else $error("search did not count down");
   a_detect_enter: assert property (@(posedge mclk) disable iff (!rstn)
      ce && tick && state_reg == CSS_SEARCH && count_reg > threshold_reg
      |=> state_reg == CSS_ACTIVE && count_reg == 8'h00) else $error("detect missed");
   a_no_early_end: assert property (@(posedge mclk) disable iff (!rstn)
      state_reg == CSS_ACTIVE && count_reg < threshold_reg |=> state_reg == CSS_ACTIVE)
      else $error("frame sync ended early");
   a_end_clear: assert property (@(posedge mclk) disable iff (!rstn)
      ce && tick && state_reg == CSS_ACTIVE && count_reg >= threshold_reg
      |=> state_reg == CSS_SEARCH && count_reg == 8'h00) else $error("end did not clear");
   a_active_hold: assert property (@(posedge mclk) disable iff (!rstn)
      ce && tick && state_reg == CSS_ACTIVE && sync_act && count_reg < threshold_reg
      |=> $stable(count_reg)) else $error("active count moved during sync");
   a_out_select: assert property (@(posedge mclk) disable iff (!rstn)
      ce && !select_reg |=> frame_sync_out == $past(ext_act)) else $error("external path wrong");
   a_tick_gap: assert property (@(posedge mclk) disable iff (!rstn)
      tick && ce ##1 ce[*2] |-> !$past(tick)) else $error("ticks too close");

   c_detect: cover property (@(posedge mclk) disable iff (!rstn)
      state_reg == CSS_SEARCH ##1 state_reg == CSS_ACTIVE);
   c_end: cover property (@(posedge mclk) disable iff (!rstn)
      state_reg == CSS_ACTIVE ##1 state_reg == CSS_SEARCH);
   c_ext: cover property (@(posedge mclk) disable iff (!rstn) !select_reg && frame_sync_out);
   // long sync pins the counter at its top
   c_saturate: cover property (@(posedge mclk) disable iff (!rstn)
      state_reg == CSS_SEARCH && count_reg == 8'hff && sync_act);
endmodule

//--- test/css_slicer_model.sv
`timescale 1ns/10ps
// stand-in for the slicer: one sync burst, high phase then low phase
module css_slicer_model (
   // clock and request
   input  wire logic       mclk,
   input  wire logic       go,
   input  wire logic [9:0] hi_len,
   input  wire logic [9:0] lo_len,
   // sliced sync and burst state
   output logic            csync,
   output logic            busy
);
   logic [10:0] cnt;
   initial begin
      csync = 1'b0;
      busy = 1'b0;
      cnt = 11'h000;
   end
   // polarity already resolved
   // sync handed over active high, whatever the source polarity was
   always @(posedge mclk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         cnt <= 11'h000;
         csync <= 1'b1;
      end else if (busy) begin
         cnt <= cnt + 11'h001;
         if (cnt + 11'h001 >= {1'b0, hi_len}) csync <= 1'b0;
         if (cnt + 11'h001 >= {1'b0, hi_len} + {1'b0, lo_len}) busy <= 1'b0;
      end
   end
endmodule

//--- test/testbench.sv
`timescale 1ns/10ps
module testbench;
   import css_pkg::*;
   typedef struct packed {logic [7:0] addr; logic [7:0] wdata; logic [7:0] rdata;} css_row_s;
   logic        mclk, rstn, ce, go, busy, csync, ext_fs, fs_out;
   logic [9:0]  hi, lo;
   logic [7:0]  rd_addr, rd_data;
   css_reg_wr_s reg_wr;
   css_status_s status;
   int          n_fail, samples_checked;
   css_row_s    rows[4] = '{'{8'h11, 8'h04, 8'h04}, '{8'h0e, 8'h00, 8'h00},
                            '{8'h0e, 8'h01, 8'h01}, '{8'h05, 8'haa, 8'h00}};
   // short tick divider keeps the run brief
   css_sync_separator #(.TICK_DIV(2)) css_sync_separator_inst (.mclk(mclk), .rstn(rstn), .ce(ce),
      .csync_in(csync), .ext_frame_sync_in(ext_fs), .reg_wr(reg_wr), .reg_rd_addr(rd_addr),
      .reg_rd_data(rd_data), .frame_sync_out(fs_out), .status(status));
   css_slicer_model css_slicer_model_inst (.mclk(mclk), .go(go), .hi_len(hi), .lo_len(lo),
      .csync(csync), .busy(busy));
   // clock
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk) reg_wr <= '{1'b1, a, d};
      @(posedge mclk) reg_wr <= '{1'b0, 8'h00, 8'h00};
   endtask
   task rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge mclk) rd_addr <= a;
      @(posedge mclk);
      #1 chk(rd_data, exp);
   endtask
   // one burst from the slicer model, bounded wait for its end
   task burst(input logic [9:0] h, input logic [9:0] l);
      int k;
      @(posedge mclk) go <= 1'b1;
      hi <= h;
      lo <= l;
      @(posedge mclk) go <= 1'b0;
      @(posedge mclk);
      #1;
      for (k = 0; k < 2000 && busy; k++) begin
         @(posedge mclk);
         #1;
      end
      if (k == 2000) n_fail++;
   endtask
   task final_report;
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog
   initial begin
      #300us;
      n_fail++;
      final_report;
   end
   // main sequence
   initial begin
      {rstn, go, ext_fs, hi, lo, rd_addr, reg_wr} = '0;
      ce = 1'b1;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      foreach (rows[i]) begin
         wr(rows[i].addr, rows[i].wdata);
         rd(rows[i].addr, rows[i].rdata);
      end
      burst(10'h006, 10'h01e);
      chk({7'h00, fs_out}, 8'h00);
      chk(status.count, 8'h00);
      burst(10'h028, 10'h000);
      chk(status.count, 8'h00);
      repeat (2) @(posedge mclk);
      #1 chk({7'h00, fs_out}, 8'h01);
      chk({7'h00, status.frame_sync}, 8'h01);
      burst(10'h00a, 10'h000);
      chk({7'h00, fs_out}, 8'h01);
      repeat (20) @(posedge mclk);
      #1 chk({7'h00, fs_out}, 8'h00);
      chk({7'h00, status.searching}, 8'h01);
      chk(status.count, 8'h00);
      wr(8'h0e, 8'h00);
      ext_fs <= 1'b1;
      repeat (4) @(posedge mclk);
      #1 chk({7'h00, fs_out}, 8'h01);
      wr(8'h0e, 8'h01);
      repeat (4) @(posedge mclk);
      #1 chk({7'h00, fs_out}, 8'h00);
      wr(8'h11, 8'hff);
      burst(10'h258, 10'h000);
      chk(status.count, 8'hff);
      chk({7'h00, fs_out}, 8'h00);
      // enable low freezes the saturated count although sync has gone
      @(posedge mclk) ce <= 1'b0;
      repeat (10) @(posedge mclk);
      #1 chk(status.count, 8'hff);
      @(posedge mclk) ce <= 1'b1;
      // mid-run reset restores register defaults
      @(posedge mclk) rstn <= 1'b0;
      repeat (20) @(posedge mclk);
      rstn <= 1'b1;
      rd(CSS_THRESHOLD_OFFSET, CSS_THRESHOLD_RESET);
      rd(CSS_SYNC_CTRL_OFFSET, 8'h01);
      chk({6'h00, fs_out, status.searching}, 8'h01);
      final_report;
   end
endmodule
